// file: rtl/flash_regs_consts.vh
// register offsets, field positions and reset values for the flash driver register slice
`ifndef FLASH_REGS_CONSTS_VH
`define FLASH_REGS_CONSTS_VH
`define ADDR_PWM_INDICATOR   8'h09
`define ADDR_CONV_HIGH       8'h0a
`define ADDR_CONV_LOW        8'h0b
`define ADDR_LOWEST_CURRENT  8'h0e
`define PWM_RESET            8'h00
`define LOWEST_RESET         8'h00
`define BIT_LOAD_BALANCE     4
`define BIT_CONST_V          5
`define BALANCE_PERCENT      8'h0f
`define PERCENT_FULL         8'h64
`define MODE_OFF             2'h0
`endif

// file: rtl/lowest_current_tracker.v
// tracks the lowest first-output current during an undervoltage reduction
`include "flash_regs_consts.vh"
module lowest_current_tracker #(
  parameter WIDTH = 8
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire             cycle_active,
  input  wire             uv_reduction,
  input  wire [WIDTH-1:0] source1_current,
  output reg  [WIDTH-1:0] lowest
);
  reg             was_active;
  reg             reduced_now;
  reg [WIDTH-1:0] running_min;

  // ===========================================
  // capture
  // ===========================================
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      was_active  <= 1'b0;
      reduced_now <= 1'b0;
      running_min <= {WIDTH{1'b1}};
      lowest      <= `LOWEST_RESET;
    end else begin
      was_active <= cycle_active;
      if (cycle_active && !was_active) begin
        reduced_now <= uv_reduction;
        running_min <= source1_current;
      end else if (cycle_active) begin
        if (uv_reduction)
          reduced_now <= 1'b1;
        if (source1_current < running_min)
          running_min <= source1_current;
      end
      // publish at end of cycle; value held until next cycle ends
      if (!cycle_active && was_active) begin
        if (reduced_now || uv_reduction)
          lowest <= running_min;
        else
          lowest <= `LOWEST_RESET;
      end
    end
  end
endmodule

// file: rtl/flash_driver_status_regs.v
// register slice: pwm/indicator upper bits, conversion result, lowest current record
`include "flash_regs_consts.vh"
module flash_driver_status_regs #(
  parameter CUR_W  = 8,
  parameter RAMP_W = 4
) (
  input  wire              mclk,
  input  wire              rst_n,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [7:0]        reg_addr,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  output reg               reg_rvalid,
  input  wire [1:0]        mode_setting,
  input  wire [CUR_W-1:0]  source1_current_setting,
  input  wire [CUR_W-1:0]  source2_current_setting,
  input  wire [9:0]        conversion_result,
  input  wire              uv_reduction,
  input  wire [CUR_W-1:0]  first_output_current,
  input  wire              flash_active,
  input  wire              balance_request_up,
  input  wire              balance_request_down,
  output reg               fixed_voltage_5v,
  output reg               balance_enable,
  output reg  [CUR_W-1:0]  source1_drive,
  output reg  [CUR_W-1:0]  source2_drive,
  output reg  [2:0]        pwm_low_bits,
  output reg               freq_switch
);
  reg  [1:0]       rst_sync;
  wire             rst_ok_n = rst_sync[1];
  reg  [7:0]       pwm_indicator_control;
  wire [CUR_W-1:0] lowest;
  reg  [CUR_W-1:0] target1;
  reg  [CUR_W-1:0] target2;
  reg  [CUR_W-1:0] trim1;
  reg  [CUR_W-1:0] next_src1;
  reg  [CUR_W-1:0] next_src2;
  reg  [CUR_W-1:0] limit1;
  reg  [CUR_W-1:0] adj1;
  reg  [CUR_W+7:0] lim_prod;
  reg  [RAMP_W-1:0] ramp_div;
  reg              ramp_tick;
  reg              trim_dir;
  wire             const_v = pwm_indicator_control[`BIT_CONST_V];
  wire             balance = pwm_indicator_control[`BIT_LOAD_BALANCE];
  reg  [CUR_W-1:0] trim_used;
  reg  [CUR_W-1:0] next_trim;
  reg              next_dir;
  reg              trim_up;
  reg              trim_down;
  reg  [7:0]       next_rdata;
  wire             hit_pwm;
  wire             hit_high;
  wire             hit_low;
  wire             hit_lowest;
  wire [2*CUR_W-1:0] goal_flat;
  wire [2*CUR_W-1:0] now_flat;
  wire [2*CUR_W-1:0] step_flat;
  genvar           ch;

  // ===========================================
  // reset release
  // ===========================================
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  // ===========================================
  // register writes
  // ===========================================
  always @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pwm_indicator_control <= `PWM_RESET;
    end else if (reg_wr && reg_addr == `ADDR_PWM_INDICATOR) begin
      pwm_indicator_control <= reg_wdata;
    end
    // result and lowest-current addresses have no write path
  end

  // ===========================================
  // register reads
  // ===========================================
  assign hit_pwm    = (reg_addr == `ADDR_PWM_INDICATOR);
  assign hit_high   = (reg_addr == `ADDR_CONV_HIGH);
  assign hit_low    = (reg_addr == `ADDR_CONV_LOW);
  assign hit_lowest = (reg_addr == `ADDR_LOWEST_CURRENT);

  // unmapped addresses read as zero
  always @* begin
    next_rdata = 8'h00;
    if (hit_pwm)
      next_rdata = pwm_indicator_control;
    else if (hit_high)
      next_rdata = conversion_result[9:2];
    else if (hit_low)
      next_rdata = {6'h00, conversion_result[1:0]};
    else if (hit_lowest)
      next_rdata = lowest;
  end

  // read data holds between reads; no capture of the two result halves together
  always @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= next_rdata;
    end
  end

  // ===========================================
  // lowest current capture
  // ===========================================
  // host reads may race the update; a flash-end read is stable
  lowest_current_tracker #(
    .WIDTH (CUR_W)
  ) u_tracker (
    .mclk            (mclk),
    .rst_n           (rst_ok_n),
    .cycle_active    (flash_active),
    .uv_reduction    (uv_reduction),
    .source1_current (first_output_current),
    .lowest          (lowest)
  );

  // ===========================================
  // ramp divider
  // ===========================================
  // ramp steps one code per tick so a normal turn-on is soft
  always @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      ramp_div  <= {RAMP_W{1'b0}};
      ramp_tick <= 1'b0;
    end else begin
      ramp_div  <= ramp_div + 1'b1;
      ramp_tick <= &ramp_div;
    end
  end

  // ===========================================
  // current targets
  // ===========================================
  always @* begin
    if (mode_setting == `MODE_OFF) begin
      target1 = {CUR_W{1'b0}};
      target2 = {CUR_W{1'b0}};
    end else begin
      target1 = source1_current_setting;
      target2 = source2_current_setting;
    end
  end

  // ===========================================
  // balance limit
  // ===========================================
  // floor of the percentage, so a very small set current gets no trim
  always @* begin
    lim_prod = target1 * `BALANCE_PERCENT / `PERCENT_FULL;
    limit1   = lim_prod[CUR_W-1:0];
  end

  // ===========================================
  // balance trim
  // ===========================================
  // requests move the trim one code per tick; conflicting requests hold it still
  always @* begin
    trim_up   = balance_request_up && !balance_request_down;
    trim_down = balance_request_down && !balance_request_up;
    next_trim = trim1;
    next_dir  = trim_dir;
    if (!balance) begin
      next_trim = {CUR_W{1'b0}};
      next_dir  = 1'b0;
    end else if (trim1 > limit1) begin
      next_trim = limit1;
    end else if (ramp_tick && (trim_up || trim_down)) begin
      if (trim1 == {CUR_W{1'b0}})
        next_dir = trim_up;
      if (trim1 == {CUR_W{1'b0}} || trim_dir == trim_up) begin
        if (trim1 < limit1)
          next_trim = trim1 + 1'b1;
      end else begin
        next_trim = trim1 - 1'b1;
      end
    end
  end

  always @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      trim1    <= {CUR_W{1'b0}};
      trim_dir <= 1'b0;
    end else begin
      trim1    <= next_trim;
      trim_dir <= next_dir;
    end
  end

  // a falling set current lowers the limit at once, so the trim is clamped here too
  always @* begin
    trim_used = (trim1 > limit1) ? limit1 : trim1;
    if (!balance)
      adj1 = target1;
    else if (trim_dir)
      adj1 = (target1 > {CUR_W{1'b1}} - trim_used) ? {CUR_W{1'b1}} : target1 + trim_used;
    else
      adj1 = (trim_used > target1) ? {CUR_W{1'b0}} : target1 - trim_used;
  end

  // ===========================================
  // source drive
  // ===========================================
  // one stepper per source; trim reaches source 1 only
  assign goal_flat = {target2, adj1};
  assign now_flat  = {source2_drive, source1_drive};

  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_step
      wire [CUR_W-1:0] goal_ch = goal_flat[ch*CUR_W +: CUR_W];
      wire [CUR_W-1:0] now_ch  = now_flat[ch*CUR_W +: CUR_W];
      reg  [CUR_W-1:0] step_ch;
      always @* begin
        step_ch = now_ch;
        if (const_v)
          step_ch = goal_ch;
        else if (ramp_tick && now_ch < goal_ch)
          step_ch = now_ch + 1'b1;
        else if (ramp_tick && now_ch > goal_ch)
          step_ch = now_ch - 1'b1;
      end
      assign step_flat[ch*CUR_W +: CUR_W] = step_ch;
    end
  endgenerate

  always @* begin
    next_src1 = step_flat[CUR_W-1:0];
    next_src2 = step_flat[2*CUR_W-1:CUR_W];
  end

  // ===========================================
  // registered outputs
  // ===========================================
  always @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      source1_drive <= {CUR_W{1'b0}};
      source2_drive <= {CUR_W{1'b0}};
    end else begin
      source1_drive <= next_src1;
      source2_drive <= next_src2;
    end
  end

  // mode bits follow the register one cycle late
  always @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      fixed_voltage_5v <= 1'b0;
      balance_enable   <= 1'b0;
      pwm_low_bits     <= 3'h0;
      freq_switch      <= 1'b0;
    end else begin
      fixed_voltage_5v <= const_v;
      balance_enable   <= balance;
      pwm_low_bits     <= pwm_indicator_control[2:0];
      freq_switch      <= pwm_indicator_control[3];
    end
  end
endmodule

// file: sim/flash_driver_status_regs_checker.sv
// concurrent checks on the ports of the flash driver register slice
module flash_driver_status_regs_checker #(
  parameter CUR_W  = 8,
  parameter RAMP_W = 4
) (
  input wire             mclk,
  input wire             rst_n,
  input wire             reg_wr,
  input wire             reg_rd,
  input wire [7:0]       reg_addr,
  input wire [7:0]       reg_wdata,
  input wire [7:0]       reg_rdata,
  input wire             reg_rvalid,
  input wire [1:0]       mode_setting,
  input wire [CUR_W-1:0] source1_current_setting,
  input wire [CUR_W-1:0] source2_current_setting,
  input wire [9:0]       conversion_result,
  input wire             uv_reduction,
  input wire             fixed_voltage_5v,
  input wire             balance_enable,
  input wire [CUR_W-1:0] source1_drive,
  input wire [CUR_W-1:0] source2_drive
);
  // ==========
  // helpers
  wire       w9 = reg_wr && reg_addr == 8'h09;
  reg  [9:0] conv_q;
  reg  [7:0] wd1;
  reg  [7:0] wd2;
  reg        w9_q;
  reg        uv_seen;
  // mode outputs lag the register by one cycle, so skip cycles near a write
  wire       steady = !w9 && !w9_q;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_q <= 10'h000;
      wd1 <= 8'h00;
      wd2 <= 8'h00;
      w9_q <= 1'b0;
      uv_seen <= 1'b0;
    end else begin
      conv_q <= conversion_result;
      wd1 <= reg_wdata;
      wd2 <= wd1;
      w9_q <= w9;
      uv_seen <= uv_seen | uv_reduction;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // assertions
  a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  a_high_read: assert property (reg_rd && reg_addr == 8'h0a |=> reg_rdata == conv_q[9:2])
    else $error("result high wrong");
  a_low_read: assert property (reg_rd && reg_addr == 8'h0b |=> reg_rdata == {6'h00, conv_q[1:0]})
    else $error("result low wrong");
  a_fixed_bit: assert property (w9 |-> ##2 fixed_voltage_5v == wd2[5]) else $error("fixed bit");
  a_balance_bit: assert property (w9 |-> ##2 balance_enable == wd2[4]) else $error("balance bit");
  a_const_drive: assert property (fixed_voltage_5v && !balance_enable && steady |=>
    source2_drive == ($past(mode_setting) == 2'h0 ? 8'h00 : $past(source2_current_setting)) &&
    source1_drive == ($past(mode_setting) == 2'h0 ? 8'h00 : $past(source1_current_setting)))
    else $error("drive not instant");
  a_ramp_step: assert property (!fixed_voltage_5v && steady |=> source2_drive == $past(source2_drive) ||
    source2_drive == $past(source2_drive) + 1 || source2_drive == $past(source2_drive) - 1)
    else $error("ramp step too big");
  a_record_zero: assert property (!uv_seen && reg_rd && reg_addr == 8'h0e |=> reg_rdata == 8'h00)
    else $error("record not zero");
endmodule

bind flash_driver_status_regs flash_driver_status_regs_checker #(.CUR_W(CUR_W), .RAMP_W(RAMP_W)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .mode_setting(mode_setting),
  .source1_current_setting(source1_current_setting), .source2_current_setting(source2_current_setting),
  .conversion_result(conversion_result), .uv_reduction(uv_reduction), .fixed_voltage_5v(fixed_voltage_5v),
  .balance_enable(balance_enable), .source1_drive(source1_drive), .source2_drive(source2_drive));

// file: sim/flash_driver_status_regs_bench.sv
// self-checking bench for the flash driver register slice
module flash_driver_status_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  reg        mclk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, uv = 1'b0, flash = 1'b0, up = 1'b0, dn = 1'b0;
  reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, s1 = 8'h00, s2 = 8'h00, cur1 = 8'h00;
  reg  [1:0] mode = 2'h0;
  reg  [9:0] conv = 10'h000;
  wire [7:0] reg_rdata, d1, d2;
  wire [2:0] pwm_low;
  wire       reg_rvalid, fixed_v, bal_en, freq_sw;
  integer    err_total = 0, tests_run = 0;
  always #50 mclk = ~mclk;
  // ramp shortened to one step per two cycles
  flash_driver_status_regs #(.CUR_W(8), .RAMP_W(1)) u_dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .mode_setting(mode), .source1_current_setting(s1), .source2_current_setting(s2), .conversion_result(conv),
    .uv_reduction(uv), .first_output_current(cur1), .flash_active(flash), .balance_request_up(up),
    .balance_request_down(dn), .fixed_voltage_5v(fixed_v), .balance_enable(bal_en), .source1_drive(d1),
    .source2_drive(d2), .pwm_low_bits(pwm_low), .freq_switch(freq_sw));
  // ==========
  // tasks
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge mclk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk({7'h00, reg_rvalid}, 8'h01);
      chk(reg_rdata, exp);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    cyc(5000);
    err_total = err_total + 1;
    complete_run;
  end
  // ==========
  // sequence
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(3);
    rd(8'h0e, 8'h00);
    wr(8'h09, 8'h35);
    rd(8'h09, 8'h35);
    chk({2'h0, fixed_v, bal_en, freq_sw, pwm_low}, 8'h35);
    wr(8'h09, 8'h20);
    @(posedge mclk);
    s1 <= 8'h40; s2 <= 8'h30; mode <= 2'h1;
    cyc(1);
    chk(d1, 8'h40);
    chk(d2, 8'h30);
    @(posedge mclk);
    mode <= 2'h0;
    cyc(1);
    chk(d2, 8'h00);
    wr(8'h09, 8'h00);
    @(posedge mclk);
    mode <= 2'h1;
    cyc(4);
    chk({7'h00, d2 < 8'h30}, 8'h01);
    cyc(200);
    chk(d2, 8'h30);
    wr(8'h09, 8'h10);
    up <= 1'b1;
    cyc(300);
    chk(d1, 8'h49);
    @(posedge mclk);
    up <= 1'b0; dn <= 1'b1;
    cyc(300);
    chk(d1, 8'h37);
    wr(8'h09, 8'h00);
    cyc(300);
    chk(d1, 8'h40);
    @(posedge mclk);
    conv <= 10'h2d6;
    rd(8'h0a, 8'hb5);
    rd(8'h0b, 8'h02);
    wr(8'h0a, 8'hff);
    rd(8'h0a, 8'hb5);
    rd(8'h33, 8'h00);
    @(posedge mclk);
    flash <= 1'b1; uv <= 1'b1; cur1 <= 8'h50;
    @(posedge mclk);
    cur1 <= 8'h28;
    @(posedge mclk);
    cur1 <= 8'h30;
    @(posedge mclk);
    flash <= 1'b0;
    cyc(3);
    rd(8'h0e, 8'h28);
    wr(8'h0e, 8'hff);
    rd(8'h0e, 8'h28);
    @(posedge mclk);
    uv <= 1'b0; flash <= 1'b1;
    cyc(4);
    @(posedge mclk);
    flash <= 1'b0;
    cyc(3);
    rd(8'h0e, 8'h00);
    complete_run;
  end
endmodule
